// >>> hw/vsf_map.svh
`ifndef VSF_MAP_SVH
`define VSF_MAP_SVH

// Register byte offsets
`define VSF_REG_SRC_FMT 4'h0
`define VSF_REG_DIAG_AB 4'h4
`define VSF_REG_DIAG_CD 4'h8
`define VSF_REG_MASK 4'hC

// Field positions
`define VSF_SRC_LSB 22
`define VSF_SRC_MSB 25
`define VSF_FMT_LSB 26
`define VSF_FMT_MSB 30
`define VSF_LOW8_BIT 31
`define VSF_WP_BIT 15
`define VSF_OWN_BIT 31
`define VSF_CSEL_BIT 31
`define VSF_LO_ADDR_LSB 0
`define VSF_LO_ADDR_MSB 14
`define VSF_HI_ADDR_LSB 16
`define VSF_HI_ADDR_MSB 30

// Reset values
`define VSF_SRC_RST 4'h0
`define VSF_FMT_RST 5'h00
`define VSF_MASK_RST 32'hFFFFFFFF
`define VSF_ADDR_RST 15'h0000

// Source selector codes
`define VSF_SRC_CAMERA 4'h0
`define VSF_SRC_NOVALID 4'h1
`define VSF_SRC_HRAMP 4'h3
`define VSF_SRC_MRAMP 4'h4
`define VSF_SRC_ZERO 4'h5
`define VSF_SRC_ONES 4'h6
`define VSF_SRC_ALT_A 4'h7
`define VSF_SRC_ALT_5 4'h8
`define VSF_SRC_SEQ 4'h9
`define VSF_SRC_VRAMP 4'hA

// Synthetic constants
`define VSF_BYTE_ZERO 8'h00
`define VSF_BYTE_ONES 8'hFF
`define VSF_BYTE_ALT_A 8'hAA
`define VSF_BYTE_ALT_5 8'h55
`define VSF_SEQ_WORD 64'hABCDEF0123456789

// Pixel format codes
`define VSF_FMT_MONO8 5'h00
`define VSF_FMT_MONO10 5'h01
`define VSF_FMT_MONO12 5'h02
`define VSF_FMT_MONO14 5'h03
`define VSF_FMT_MONO16 5'h04
`define VSF_FMT_BGR8_32 5'h05
`define VSF_FMT_BGR8_24 5'h06
`define VSF_FMT_RGB10_32 5'h07
`define VSF_FMT_RGB12_48 5'h08
`define VSF_FMT_MONO32 5'h09
`define VSF_FMT_MONO64 5'h0A
`define VSF_FMT_RGB8_32 5'h0B
`define VSF_FMT_RGB8_24 5'h0C
`define VSF_FMT_BGR10_32 5'h0D
`define VSF_FMT_BGR12_48 5'h0E

// Low-byte keep masks per pixel container
`define VSF_KEEP_ALL 64'hFFFFFFFFFFFFFFFF
`define VSF_KEEP_16 64'h00FF00FF00FF00FF
`define VSF_KEEP_32 64'h000000FF000000FF
`define VSF_KEEP_64 64'h00000000000000FF
`define VSF_KEEP_C10 64'h000000000FF3FCFF
`define VSF_KEEP_C12 64'h00000000FF0FF0FF

// Lanes written per format
`define VSF_LANES_ALL 4'hF
`define VSF_LANES_48 4'h7
`define VSF_LANES_32 4'h3
`define VSF_LANES_NONE 4'h0

`endif

// >>> hw/vsf_pattern_gen.sv
`timescale 1ns/10ps
`default_nettype none
`include "vsf_map.svh"

module vsf_pattern_gen (
	// Clock and control
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [3:0] src_i,
	// Pattern out
	output logic [63:0] pat_o
);
	logic [7:0] h_q;
	logic [7:0] v_q;
	logic [7:0] f_q;
	logic [7:0] byte_d;
	logic [63:0] pat_d;

	// Free-running raster: no camera timing exists in synthetic mode
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			h_q <= 8'h00;
			v_q <= 8'h00;
			f_q <= 8'h00;
		end else if (ce_i) begin
			h_q <= h_q + 8'h01;
			if (h_q == 8'hFF) begin
				v_q <= v_q + 8'h01;
				if (v_q == 8'hFF)
					f_q <= f_q + 8'h01;
			end
		end
	end

	// One byte value per code, copied to every tap; the fixed-word code gives the whole 64-bit word
	always_comb begin
		byte_d = `VSF_BYTE_ZERO;
		unique case (src_i)
			`VSF_SRC_HRAMP: byte_d = h_q;
			`VSF_SRC_MRAMP: byte_d = h_q + f_q;
			`VSF_SRC_VRAMP: byte_d = v_q;
			`VSF_SRC_ONES: byte_d = `VSF_BYTE_ONES;
			`VSF_SRC_ALT_A: byte_d = `VSF_BYTE_ALT_A;
			`VSF_SRC_ALT_5: byte_d = `VSF_BYTE_ALT_5;
			default: byte_d = `VSF_BYTE_ZERO;
		endcase
		pat_d = {8{byte_d}};
		if (src_i == `VSF_SRC_SEQ)
			pat_d = `VSF_SEQ_WORD;
	end

	// Registered so the source mux sees a clean word
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i)
			pat_o <= 64'h0000000000000000;
		else if (ce_i)
			pat_o <= pat_d;
	end
endmodule : vsf_pattern_gen

`default_nettype wire

// >>> hw/vsf_pkg.sv
package vsf_pkg;
	typedef logic [14:0] vsf_addr_t;

	// Register port request, one strobe at a time
	typedef struct packed {
		logic wr;
		logic rd;
		logic [3:0] addr;
		logic [31:0] wdata;
	} vsf_bus_req_s;

	// Buffer write towards the dual-port buffer, one enable per lane
	typedef struct packed {
		logic [3:0] we;
		vsf_addr_t [3:0] addr;
		logic [63:0] data;
	} vsf_buf_wr_s;
endpackage : vsf_pkg

// >>> hw/vsf_top.sv
// Local design decisions: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "vsf_map.svh"

module vsf_top (
	// Clock, reset, enable
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	// Register port
	input wire vsf_pkg::vsf_bus_req_s bus_i,
	output logic [31:0] rd_data_o,
	// Camera pins
	input wire logic [63:0] cam_data_i,
	input wire logic cam_valid_i,
	// Video stream out
	output logic [63:0] pix_o,
	output logic pix_valid_o,
	// Buffer write port
	output vsf_pkg::vsf_buf_wr_s buf_wr_o,
	// UART sharing and colour space
	input wire logic uart_taken_i,
	output logic uart_owner_o,
	output logic color_space_o
);
	// Configuration
	logic [3:0] video_source_select_q;
	logic [4:0] pixel_format_code_q;
	logic low_byte_only_q;
	logic buffer_write_protect_q;
	logic [31:0] mask_q;
	// Input synchronisers
	logic [63:0] cam_s1_q, cam_s2_q, cam_s3_q;
	logic val_s1_q, val_s2_q, val_s3_q;
	logic val_filt_q;
	// Datapath
	logic [63:0] pat;
	logic [63:0] raw_d, pix_d;
	logic pix_valid_d;
	vsf_pkg::vsf_addr_t [3:0] lane_addr_q;
	vsf_pkg::vsf_addr_t [3:0] last_q;
	logic [3:0] lanes;
	logic [31:0] rd_d;

	// Rearrange camera components into the selected layout
	function automatic logic [63:0] fmt_pack(input logic [4:0] f, input logic [63:0] d);
		logic [63:0] r;
		r = d;
		unique case (f)
			`VSF_FMT_RGB8_32: r = {8'h00, d[39:32], d[47:40], d[55:48],
				8'h00, d[7:0], d[15:8], d[23:16]};
			`VSF_FMT_BGR8_32: r = {8'h00, d[55:48], d[47:40], d[39:32],
				8'h00, d[23:16], d[15:8], d[7:0]};
			`VSF_FMT_RGB8_24: r = {16'h0000, d[39:32], d[47:40], d[55:48],
				d[7:0], d[15:8], d[23:16]};
			`VSF_FMT_BGR8_24: r = {16'h0000, d[55:48], d[47:40], d[39:32],
				d[23:16], d[15:8], d[7:0]};
			`VSF_FMT_RGB10_32: r = {32'h00000000, 2'b00, d[9:0], d[25:16], d[41:32]};
			`VSF_FMT_BGR10_32: r = {32'h00000000, 2'b00, d[41:32], d[25:16], d[9:0]};
			`VSF_FMT_RGB12_48: r = {28'h0000000, d[11:0], d[27:16], d[43:32]};
			`VSF_FMT_BGR12_48: r = {28'h0000000, d[43:32], d[27:16], d[11:0]};
			default: r = d;
		endcase
		return r;
	endfunction : fmt_pack

	// Bits kept when only the low byte of each pixel is captured
	function automatic logic [63:0] low8_keep(input logic [4:0] f);
		logic [63:0] k;
		k = `VSF_KEEP_ALL;
		unique case (f)
			`VSF_FMT_MONO10,
			`VSF_FMT_MONO12,
			`VSF_FMT_MONO14,
			`VSF_FMT_MONO16: k = `VSF_KEEP_16;
			`VSF_FMT_MONO32: k = `VSF_KEEP_32;
			`VSF_FMT_MONO64: k = `VSF_KEEP_64;
			`VSF_FMT_RGB10_32,
			`VSF_FMT_BGR10_32: k = `VSF_KEEP_C10;
			`VSF_FMT_RGB12_48,
			`VSF_FMT_BGR12_48: k = `VSF_KEEP_C12;
			default: k = `VSF_KEEP_ALL;
		endcase
		return k;
	endfunction : low8_keep

	// Lanes that carry data in each format; undefined codes write nothing
	function automatic logic [3:0] lane_use(input logic [4:0] f);
		logic [3:0] l;
		l = `VSF_LANES_NONE;
		unique case (f)
			`VSF_FMT_BGR8_24,
			`VSF_FMT_RGB8_24,
			`VSF_FMT_RGB12_48,
			`VSF_FMT_BGR12_48: l = `VSF_LANES_48;
			`VSF_FMT_RGB10_32,
			`VSF_FMT_BGR10_32: l = `VSF_LANES_32;
			`VSF_FMT_MONO8, `VSF_FMT_MONO10, `VSF_FMT_MONO12, `VSF_FMT_MONO14,
			`VSF_FMT_MONO16, `VSF_FMT_BGR8_32, `VSF_FMT_RGB8_32,
			`VSF_FMT_MONO32, `VSF_FMT_MONO64: l = `VSF_LANES_ALL;
			default: l = `VSF_LANES_NONE;
		endcase
		return l;
	endfunction : lane_use

	// Source, format and low-byte control
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			video_source_select_q <= `VSF_SRC_RST;
			pixel_format_code_q <= `VSF_FMT_RST;
			low_byte_only_q <= 1'b0;
		end else if (ce_i && bus_i.wr && bus_i.addr == `VSF_REG_SRC_FMT) begin
			video_source_select_q <= bus_i.wdata[`VSF_SRC_MSB:`VSF_SRC_LSB];
			pixel_format_code_q <= bus_i.wdata[`VSF_FMT_MSB:`VSF_FMT_LSB];
			low_byte_only_q <= bus_i.wdata[`VSF_LOW8_BIT];
		end
	end

	// Write protect; ownership is set by software and lost to another grabber
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			buffer_write_protect_q <= 1'b0;
			uart_owner_o <= 1'b0;
		end else if (ce_i) begin
			if (bus_i.wr && bus_i.addr == `VSF_REG_DIAG_AB) begin
				buffer_write_protect_q <= bus_i.wdata[`VSF_WP_BIT];
				uart_owner_o <= bus_i.wdata[`VSF_OWN_BIT];
			end else if (uart_taken_i) begin
				uart_owner_o <= 1'b0; // Software write wins over a takeover
			end
		end
	end

	// Colour space and video mask
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			color_space_o <= 1'b0;
			mask_q <= `VSF_MASK_RST;
		end else if (ce_i && bus_i.wr) begin
			if (bus_i.addr == `VSF_REG_DIAG_CD)
				color_space_o <= bus_i.wdata[`VSF_CSEL_BIT];
			if (bus_i.addr == `VSF_REG_MASK)
				mask_q <= bus_i.wdata;
		end
	end

	// Camera pins cross in through three stages
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cam_s1_q <= 64'h0000000000000000;
			cam_s2_q <= 64'h0000000000000000;
			cam_s3_q <= 64'h0000000000000000;
			val_s1_q <= 1'b0;
			val_s2_q <= 1'b0;
			val_s3_q <= 1'b0;
			val_filt_q <= 1'b0;
		end else if (ce_i) begin
			cam_s1_q <= cam_data_i;
			cam_s2_q <= cam_s1_q;
			cam_s3_q <= cam_s2_q;
			val_s1_q <= cam_valid_i;
			val_s2_q <= val_s1_q;
			val_s3_q <= val_s2_q;
			if (val_s2_q == val_s3_q)
				val_filt_q <= val_s3_q; // A glitch of one cycle never counts
		end
	end

	vsf_pattern_gen u_pattern (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.src_i(video_source_select_q),
		.pat_o(pat)
	);

	// Source select, packing, low-byte cut and mask
	always_comb begin
		raw_d = pat;
		pix_valid_d = 1'b1;
		unique case (video_source_select_q)
			`VSF_SRC_CAMERA: begin
				raw_d = cam_s3_q;
				pix_valid_d = val_filt_q;
			end
			`VSF_SRC_NOVALID: begin
				raw_d = cam_s3_q;
				pix_valid_d = 1'b1;
			end
			`VSF_SRC_HRAMP, `VSF_SRC_MRAMP, `VSF_SRC_ZERO, `VSF_SRC_ONES, `VSF_SRC_ALT_A,
			`VSF_SRC_ALT_5, `VSF_SRC_SEQ, `VSF_SRC_VRAMP: pix_valid_d = 1'b1;
			default: pix_valid_d = 1'b0; // Reserved codes stream nothing
		endcase
		// Test patterns bypass packing; the low-byte cut and the mask still apply to them
		if (video_source_select_q == `VSF_SRC_CAMERA ||
			video_source_select_q == `VSF_SRC_NOVALID)
			pix_d = fmt_pack(pixel_format_code_q, raw_d);
		else
			pix_d = raw_d;
		if (low_byte_only_q)
			pix_d = pix_d & low8_keep(pixel_format_code_q);
		pix_d = pix_d & {mask_q, mask_q};
	end

	// Stream output register
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pix_o <= 64'h0000000000000000;
			pix_valid_o <= 1'b0;
		end else if (ce_i) begin
			pix_o <= pix_d;
			pix_valid_o <= pix_valid_d;
		end
	end

	assign lanes = pix_valid_o && !buffer_write_protect_q ?
		lane_use(pixel_format_code_q) : `VSF_LANES_NONE;

	// Buffer write issue with one address counter per lane
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			buf_wr_o <= '0;
			lane_addr_q <= '0;
		end else if (ce_i) begin
			buf_wr_o.we <= lanes;
			buf_wr_o.data <= pix_o;
			buf_wr_o.addr <= lane_addr_q;
			for (int l = 0; l < 4; l++) begin
				if (lanes[l])
					lane_addr_q[l] <= lane_addr_q[l] + 15'h0001;
			end
		end
	end

	// Diagnostic last addresses follow each completed lane write
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			last_q <= '0;
		end else if (ce_i) begin
			for (int l = 0; l < 4; l++) begin
				if (buf_wr_o.we[l])
					last_q[l] <= buf_wr_o.addr[l];
			end
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb begin
		rd_d = 32'h00000000;
		unique case (bus_i.addr)
			`VSF_REG_SRC_FMT: begin
				rd_d[`VSF_SRC_MSB:`VSF_SRC_LSB] = video_source_select_q;
				rd_d[`VSF_FMT_MSB:`VSF_FMT_LSB] = pixel_format_code_q;
				rd_d[`VSF_LOW8_BIT] = low_byte_only_q;
			end
			`VSF_REG_DIAG_AB: begin
				rd_d[`VSF_LO_ADDR_MSB:`VSF_LO_ADDR_LSB] = last_q[0];
				rd_d[`VSF_WP_BIT] = buffer_write_protect_q;
				rd_d[`VSF_HI_ADDR_MSB:`VSF_HI_ADDR_LSB] = last_q[1];
				rd_d[`VSF_OWN_BIT] = uart_owner_o;
			end
			`VSF_REG_DIAG_CD: begin
				rd_d[`VSF_LO_ADDR_MSB:`VSF_LO_ADDR_LSB] = last_q[2];
				rd_d[`VSF_HI_ADDR_MSB:`VSF_HI_ADDR_LSB] = last_q[3];
				rd_d[`VSF_CSEL_BIT] = color_space_o;
			end
			`VSF_REG_MASK: rd_d = mask_q;
			default: rd_d = 32'h00000000;
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i)
			rd_data_o <= 32'h00000000;
		else if (ce_i)
			rd_data_o <= bus_i.rd ? rd_d : 32'h00000000;
	end

	property p_src_novalid;
		@(posedge mclk_i) disable iff (!rst_n_i)
		ce_i && video_source_select_q == `VSF_SRC_NOVALID |=> pix_valid_o;
	endproperty
	a_src_novalid: assert property (p_src_novalid) else $error("valid not forced in mode 1");

	property p_ones;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(ce_i && !bus_i.wr && video_source_select_q == `VSF_SRC_ONES)[*3]
		|=> pix_o == ({mask_q, mask_q} &
			(low_byte_only_q ? low8_keep(pixel_format_code_q) : `VSF_KEEP_ALL));
	endproperty
	a_ones: assert property (p_ones) else $error("FFh pattern wrong");

	property p_seq;
		@(posedge mclk_i) disable iff (!rst_n_i)
		(ce_i && !bus_i.wr && video_source_select_q == `VSF_SRC_SEQ)[*3]
		|=> pix_o == (`VSF_SEQ_WORD & {mask_q, mask_q} &
			(low_byte_only_q ? low8_keep(pixel_format_code_q) : `VSF_KEEP_ALL));
	endproperty
	a_seq: assert property (p_seq) else $error("fixed word pattern wrong");

	property p_low8;
		@(posedge mclk_i) disable iff (!rst_n_i)
		ce_i && low_byte_only_q && pixel_format_code_q == `VSF_FMT_MONO16
		|=> (pix_o & ~`VSF_KEEP_16) == 64'h0000000000000000;
	endproperty
	a_low8: assert property (p_low8) else $error("high pixel bits survived");

	property p_wp;
		@(posedge mclk_i) disable iff (!rst_n_i)
		ce_i && buffer_write_protect_q |=> buf_wr_o.we == `VSF_LANES_NONE;
	endproperty
	a_wp: assert property (p_wp) else $error("buffer written while protected");

	property p_last_a;
		@(posedge mclk_i) disable iff (!rst_n_i)
		ce_i && buf_wr_o.we[0] |=> last_q[0] == $past(buf_wr_o.addr[0]);
	endproperty
	a_last_a: assert property (p_last_a) else $error("lane A last address stale");

	property p_last_d;
		@(posedge mclk_i) disable iff (!rst_n_i)
		ce_i && buf_wr_o.we[3] ##1 ce_i && bus_i.rd && bus_i.addr == `VSF_REG_DIAG_CD
		|=> rd_data_o[`VSF_HI_ADDR_MSB:`VSF_HI_ADDR_LSB] == $past(buf_wr_o.addr[3], 2);
	endproperty
	a_last_d: assert property (p_last_d) else $error("lane D readback wrong");

	property p_own;
		@(posedge mclk_i) disable iff (!rst_n_i)
		ce_i && bus_i.wr && bus_i.addr == `VSF_REG_DIAG_AB && bus_i.wdata[`VSF_OWN_BIT]
		|=> uart_owner_o;
	endproperty
	a_own: assert property (p_own) else $error("UART ownership not taken");

	property p_mask;
		@(posedge mclk_i) disable iff (!rst_n_i)
		ce_i ##1 $stable(mask_q) |-> (pix_o & ~{mask_q, mask_q}) == 64'h0000000000000000;
	endproperty
	a_mask: assert property (p_mask) else $error("masked video bit set");
endmodule : vsf_top

`default_nettype wire

// >>> sim/vsf_cam_model.sv
`timescale 1ns/10ps
`default_nettype none

module vsf_cam_model (
	// Clock and scenario control
	input wire logic mclk_i,
	input wire logic drive_i,
	input wire logic valid_i,
	input wire logic [63:0] word_i,
	// Camera pins
	output logic [63:0] cam_data_o,
	output logic cam_valid_o
);
	// Between words the pins toggle, so stale data can never pass for fresh data
	initial begin
		cam_data_o = 64'h0000000000000000;
		cam_valid_o = 1'b0;
	end

	// Valid qualifies the word only while the camera drives it
	always @(posedge mclk_i) begin
		if (drive_i) begin
			cam_data_o <= word_i;
		end else begin
			cam_data_o <= ~cam_data_o;
		end
		cam_valid_o <= drive_i & valid_i;
	end
endmodule : vsf_cam_model

`default_nettype wire

// >>> sim/vsf_top_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "vsf_map.svh"

module vsf_top_tb_top;
	typedef struct {
		logic [3:0] src;
		logic [4:0] fmt;
		logic low8;
		logic [31:0] mask;
		logic [63:0] pix;
	} vsf_row_s;

	logic mclk_i;
	logic rst_n_i;
	logic uart_taken;
	logic cam_drive;
	logic cam_vld;
	logic [63:0] cam_word;
	logic [63:0] cam_data;
	logic cam_valid;
	logic [31:0] rd_data;
	logic [63:0] pix;
	logic pix_valid;
	logic uart_owner;
	logic color_space;
	vsf_pkg::vsf_bus_req_s bus;
	vsf_pkg::vsf_buf_wr_s buf_wr;
	logic [14:0] last_q [4];
	int fails;
	int tests_run;
	vsf_row_s rows [9];

	vsf_top vsf_top_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .bus_i(bus),
		.rd_data_o(rd_data), .cam_data_i(cam_data), .cam_valid_i(cam_valid), .pix_o(pix),
		.pix_valid_o(pix_valid), .buf_wr_o(buf_wr), .uart_taken_i(uart_taken),
		.uart_owner_o(uart_owner), .color_space_o(color_space));

	vsf_cam_model vsf_cam_model_i (.mclk_i(mclk_i), .drive_i(cam_drive), .valid_i(cam_vld),
		.word_i(cam_word), .cam_data_o(cam_data), .cam_valid_o(cam_valid));

	// Clock at 100 MHz
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	// Remember the buffer address each lane wrote last
	always @(posedge mclk_i) begin
		for (int l = 0; l < 4; l++) begin
			if (buf_wr.we[l] === 1'b1) begin
				last_q[l] <= buf_wr.addr[l];
			end
		end
	end

	task automatic finish_test();
		if (fails == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Waits n edges and lands just after the last, where outputs have settled
	task automatic tick(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask : tick

	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		tick(1);
		bus <= '0;
		tick(1);
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h00000000};
		tick(1);
		bus <= '0;
		check(64'(rd_data), 64'(exp));
		tick(1);
	endtask : rd_reg

	function automatic logic [3:0] lanes(input logic [4:0] f);
		case (f)
			5'h06, 5'h08, 5'h0C, 5'h0E: lanes = 4'h7;
			5'h07, 5'h0D: lanes = 4'h3;
			5'h0F: lanes = 4'h0;
			default: lanes = 4'hF;
		endcase
	endfunction : lanes

	// A hang is cut short well past the expected run time
	initial begin
		#200us;
		fails++;
		finish_test();
	end

	// Main sequence
	initial begin
		rst_n_i = 1'b0;
		bus = '0;
		uart_taken = 1'b0;
		cam_drive = 1'b0;
		cam_vld = 1'b0;
		cam_word = 64'h0000000000000000;
		fails = 0;
		tests_run = 0;
		rows = '{
			'{4'h5, 5'h00, 1'b0, 32'hFFFFFFFF, 64'h0000000000000000},
			'{4'h6, 5'h00, 1'b0, 32'hFFFFFFFF, 64'hFFFFFFFFFFFFFFFF},
			'{4'h7, 5'h00, 1'b0, 32'hFFFFFFFF, 64'hAAAAAAAAAAAAAAAA},
			'{4'h8, 5'h00, 1'b0, 32'hFFFFFFFF, 64'h5555555555555555},
			'{4'h9, 5'h00, 1'b0, 32'hFFFFFFFF, 64'hABCDEF0123456789},
			'{4'h6, 5'h00, 1'b0, 32'h0F0F00FF, 64'h0F0F00FF0F0F00FF},
			'{4'h6, 5'h04, 1'b1, 32'hFFFFFFFF, 64'h00FF00FF00FF00FF},
			'{4'h6, 5'h09, 1'b1, 32'hFFFFFFFF, 64'h000000FF000000FF},
			'{4'h6, 5'h0A, 1'b1, 32'hFFFFFFFF, 64'h00000000000000FF}};
		tick(2);
		rst_n_i <= 1'b1;
		// Reset values, then an unmapped place
		rd_reg(`VSF_REG_SRC_FMT, 32'h00000000);
		rd_reg(`VSF_REG_MASK, `VSF_MASK_RST);
		rd_reg(`VSF_REG_DIAG_AB, 32'h00000000);
		rd_reg(`VSF_REG_DIAG_CD, 32'h00000000);
		rd_reg(4'h2, 32'h00000000);
		check(64'(pix_valid), 64'h0);
		// Synthetic patterns, masking and low-byte cut
		foreach (rows[i]) begin
			wr_reg(`VSF_REG_SRC_FMT, {rows[i].low8, rows[i].fmt, rows[i].src, 22'h000000});
			wr_reg(`VSF_REG_MASK, rows[i].mask);
			tick(4);
			check(pix, rows[i].pix);
			check(64'(pix_valid), 64'h1);
		end
		rd_reg(`VSF_REG_SRC_FMT, 32'hA9800000);
		wr_reg(`VSF_REG_MASK, 32'hFFFFFFFF);
		// Ramps repeat one byte on every tap; horizontal and moving ramps step each word
		for (int s = 0; s < 3; s++) begin
			logic [7:0] b;
			wr_reg(`VSF_REG_SRC_FMT, {6'h00, (s == 0) ? 4'h3 : (s == 1) ? 4'h4 : 4'hA, 22'h000000});
			tick(6);
			check(pix, {8{pix[7:0]}});
			b = pix[7:0];
			tick(1);
			if (s < 2)
				check(pix, {8{b + 8'h01}});
		end
		// Reserved source code streams nothing
		wr_reg(`VSF_REG_SRC_FMT, {6'h00, 4'h2, 22'h000000});
		tick(3);
		check(64'(pix_valid), 64'h0);
		// Lanes written per format, undefined code writes none
		for (int f = 0; f < 16; f++) begin
			wr_reg(`VSF_REG_SRC_FMT, {1'b0, 5'(f), 4'h6, 22'h000000});
			tick(5);
			check(64'(buf_wr.we), 64'(lanes(5'(f))));
		end
		wr_reg(`VSF_REG_SRC_FMT, {1'b0, 5'h00, 4'h6, 22'h000000});
		tick(6);
		// Lane C and D fields read back while all lanes are still writing
		rd_reg(`VSF_REG_DIAG_CD, {1'b0, last_q[3], 1'b0, last_q[2]});
		// Protect the buffer; address fields must ignore the write
		wr_reg(`VSF_REG_DIAG_AB, 32'h7FFFFFFF);
		tick(6);
		check(64'(buf_wr.we), 64'h0);
		rd_reg(`VSF_REG_DIAG_AB, {1'b0, last_q[1], 1'b1, last_q[0]});
		rd_reg(`VSF_REG_DIAG_CD, {1'b0, last_q[3], 1'b0, last_q[2]});
		check(64'(buf_wr.we), 64'h0);
		// UART hand-over and colour space
		wr_reg(`VSF_REG_DIAG_AB, 32'h80000000);
		tick(1);
		check(64'(uart_owner), 64'h1);
		uart_taken <= 1'b1;
		tick(1);
		uart_taken <= 1'b0;
		tick(2);
		check(64'(uart_owner), 64'h0);
		wr_reg(`VSF_REG_DIAG_CD, 32'h80000000);
		tick(1);
		check(64'(color_space), 64'h1);
		// Live camera with and without its valid qualifier
		wr_reg(`VSF_REG_SRC_FMT, 32'h00000000);
		cam_word <= 64'h0123456789ABCDEF;
		cam_drive <= 1'b1;
		cam_vld <= 1'b1;
		tick(8);
		check(pix, 64'h0123456789ABCDEF);
		check(64'(pix_valid), 64'h1);
		cam_vld <= 1'b0;
		tick(8);
		check(64'(pix_valid), 64'h0);
		wr_reg(`VSF_REG_SRC_FMT, 32'h00400000);
		tick(8);
		check(64'(pix_valid), 64'h1);
		check(pix, 64'h0123456789ABCDEF);
		// Colour packing of camera data, red in the top component
		wr_reg(`VSF_REG_SRC_FMT, 32'h2C400000);
		tick(2);
		check(pix, 64'h0067452300EFCDAB);
		wr_reg(`VSF_REG_SRC_FMT, 32'h20400000);
		tick(2);
		check(pix, 64'h0000000DEF9AB567);
		finish_test();
	end
endmodule : vsf_top_tb_top

`default_nettype wire
